//--- srx_pkg.sv
// Constants, types and register map of the two-wire slave receiver.
// Assumes an APB master with 32-bit data on the same clock as the block.
//
// Behaviour
// - Status codes assume prescaler field masked zero
// - Upper seven own-address bits give slave address
// - Own-address bit zero enables general call 0x00
// - Address acknowledged only while ack enable set
// - Direction bit zero selects slave receive
// - Own address write sets flag and status
// - Lost arbitration entry reports 0x68 or 0x78
// - Cleared ack enable gives NACK after next byte
// - Ack enable zero isolates; recognition resumes when set
// - Sleep still matches address with ack enable
// - Sleep match wakes part, stretches SCL until clear
// - Data register not updated while asleep
// - 0x60 own address write acknowledged
// - 0x68 arbitration lost, own address acknowledged
// - 0x70 general call acknowledged
// - 0x78 arbitration lost, general call acknowledged
// - 0x80 own data byte ACKed, software reads
// - 0x88 NACKed; clear returns to unaddressed slave
// - Leaving addressed: recognition per ack; start request
// - 0x90 and 0x98 general call data codes
// - 0xA0 STOP or repeated START while addressed
package srx_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA   = 8'h08;
    localparam logic [7:0] OFF_OWN    = 8'h0C;

    // ----------------------------------------
    // Control bit positions
    // ----------------------------------------
    localparam int CB_IRQ_FLAG  = 7;
    localparam int CB_ACK_EN    = 6;
    localparam int CB_START     = 5;
    localparam int CB_STOP      = 4;
    localparam int CB_WCOL      = 3;
    localparam int CB_IFACE_EN  = 2;
    localparam int CB_IRQ_EN    = 0;

    // ----------------------------------------
    // Reset values and misc
    // ----------------------------------------
    localparam logic [7:0] RST_OWN    = 8'h00;
    localparam logic [7:0] RST_DATA   = 8'hFF;
    localparam logic [7:0] GC_ADDR    = 8'h00;
    localparam logic [3:0] BITS_BYTE  = 4'h8;

    // ----------------------------------------
    // Status codes (prescaler bits zero)
    // ----------------------------------------
    localparam logic [7:0] SC_IDLE    = 8'hF8;
    localparam logic [7:0] SC_OWN_W   = 8'h60;
    localparam logic [7:0] SC_ARB_OWN = 8'h68;
    localparam logic [7:0] SC_GC      = 8'h70;
    localparam logic [7:0] SC_ARB_GC  = 8'h78;
    localparam logic [7:0] SC_DAT_ACK = 8'h80;
    localparam logic [7:0] SC_DAT_NAK = 8'h88;
    localparam logic [7:0] SC_GCD_ACK = 8'h90;
    localparam logic [7:0] SC_GCD_NAK = 8'h98;
    localparam logic [7:0] SC_STOP    = 8'hA0;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_DATA = 7'h08,
        ST_DACK = 7'h10,
        ST_HOLD = 7'h20,
        ST_SKIP = 7'h40
    } srx_state_t;

    typedef struct packed {
        logic       paddr_ok;
        logic [7:0] paddr;
        logic       pwrite;
        logic [7:0] pwdata;
    } srx_apb_req_t;

    typedef struct packed {
        srx_state_t  state;
        logic        scl_m;
        logic        scl_s;
        logic        scl_p;
        logic        sda_m;
        logic        sda_s;
        logic        sda_p;
        logic        busy;
        logic [7:0]  shift;
        logic [3:0]  bit_cnt;
        logic        gc_hit;
        logic        arb_seen;
        logic        ack_plan;
        logic [7:0]  own_addr;
        logic        irq_flag;
        logic        ack_enable;
        logic        start_request;
        logic        stop_request;
        logic        write_collision;
        logic        iface_enable;
        logic        irq_enable;
        logic [1:0]  presc;
        logic [7:0]  status;
        logic [7:0]  data;
        logic        sda_oe;
        logic        scl_oe;
        logic        irq;
        logic        wake;
        logic        start_out;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } srx_st_t;

endpackage

//--- srx_slave_rx.sv
// Two-wire slave receiver with APB register access.
// Assumes SCL and SDA come from pins and arb_lost/sleep_i from same-clock logic.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module srx_slave_rx
    import srx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              core_clk,  // System clock, 40 MHz
    input  wire logic              rst,       // Synchronous reset, active high
    input  wire logic              psel,      // APB select
    input  wire logic              penable,   // APB access phase
    input  wire logic              pwrite,    // APB direction, 1 = write
    input  wire logic [ADDR_W-1:0] paddr,     // APB byte address
    input  wire logic [31:0]       pwdata,    // APB write data
    output logic      [31:0]       prdata,    // APB read data
    output logic                   pready,    // APB ready
    output logic                   pslverr,   // APB error, unmapped address
    input  wire logic              scl_i,     // SCL pin level
    output logic                   scl_o,     // SCL drive value, always low
    output logic                   scl_oe,    // SCL pulled low while high
    input  wire logic              sda_i,     // SDA pin level
    output logic                   sda_o,     // SDA drive value, always low
    output logic                   sda_oe,    // SDA pulled low while high
    input  wire logic              arb_lost,  // Pulse: master lost arbitration
    input  wire logic              sleep_i,   // Part is in a deep sleep mode
    output logic                   wake_o,    // Wake request to power control
    output logic                   start_o,   // Start wanted and bus free
    output logic                   irq_o      // Flag and enable both set
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be 8..32");
    end

    srx_st_t r;
    srx_st_t n;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    logic own_hit;
    logic gc_match;
    logic addressed;
    logic sel_ok;
    logic [7:0] adr;

    // ----------------------------------------
    // Output taps
    // ----------------------------------------
    assign scl_o   = 1'b0;
    assign sda_o   = 1'b0;
    assign prdata  = r.prdata;
    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign scl_oe  = r.scl_oe;
    assign sda_oe  = r.sda_oe;
    assign wake_o  = r.wake;
    assign start_o = r.start_out;
    assign irq_o   = r.irq;

    // ----------------------------------------
    // Bus condition decode
    // ----------------------------------------
    assign scl_rise  = r.scl_s & ~r.scl_p;
    assign scl_fall  = ~r.scl_s & r.scl_p;
    assign start_c   = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
    assign stop_c    = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
    assign own_hit   = (r.shift[7:1] == r.own_addr[7:1]) & ~r.shift[0];
    assign gc_match  = (r.shift == GC_ADDR) & r.own_addr[0];
    assign addressed = (r.state == ST_DATA) | (r.state == ST_DACK);
    assign adr       = paddr[7:0];
    assign sel_ok    = (adr == OFF_CTRL)   |
                       (adr == OFF_STATUS) |
                       (adr == OFF_DATA)   |
                       (adr == OFF_OWN);

    always_comb begin
        n = r;
        n.scl_m = scl_i;
        n.scl_s = r.scl_m;
        n.scl_p = r.scl_s;
        n.sda_m = sda_i;
        n.sda_s = r.sda_m;
        n.sda_p = r.sda_s;

        // ----------------------------------------
        // APB slave: answer one cycle into access
        // ----------------------------------------
        n.pready  = psel & penable & ~r.pready;
        n.pslverr = psel & penable & ~r.pready & ~sel_ok;
        n.prdata  = 32'h0000_0000;
        if (psel & penable & ~r.pready) begin
            case (adr)
                OFF_CTRL: begin
                    n.prdata[CB_IRQ_FLAG] = r.irq_flag;
                    n.prdata[CB_ACK_EN]   = r.ack_enable;
                    n.prdata[CB_START]    = r.start_request;
                    n.prdata[CB_STOP]     = r.stop_request;
                    n.prdata[CB_WCOL]     = r.write_collision;
                    n.prdata[CB_IFACE_EN] = r.iface_enable;
                    n.prdata[CB_IRQ_EN]   = r.irq_enable;
                end

                OFF_STATUS: begin
                    n.prdata[7:0] = {r.status[7:3], 1'b0, r.presc};
                end

                OFF_DATA: begin
                    n.prdata[7:0] = r.data;
                end

                OFF_OWN: begin
                    n.prdata[7:0] = r.own_addr;
                end

                default: begin
                    n.prdata = 32'h0000_0000;
                end
            endcase
        end

        if (psel & penable & r.pready & pwrite & sel_ok) begin
            case (adr)
                OFF_CTRL: begin
                    if (pwdata[CB_IRQ_FLAG]) begin
                        n.irq_flag = 1'b0;
                    end
                    n.ack_enable    = pwdata[CB_ACK_EN];
                    n.start_request = pwdata[CB_START];
                    n.stop_request  = pwdata[CB_STOP];
                    n.iface_enable  = pwdata[CB_IFACE_EN];
                    n.irq_enable    = pwdata[CB_IRQ_EN];
                end

                OFF_STATUS: begin
                    n.presc = pwdata[1:0];
                end

                OFF_DATA: begin
                    if (r.irq_flag) begin
                        n.data = pwdata[7:0];
                    end else begin
                        n.write_collision = 1'b1;
                    end
                end

                OFF_OWN: begin
                    n.own_addr = pwdata[7:0];
                end

                default: begin
                    n.presc = r.presc;
                end
            endcase

            if (adr == OFF_DATA && r.irq_flag) begin
                n.write_collision = 1'b0;
            end
        end

        // ----------------------------------------
        // Link side
        // ----------------------------------------
        if (arb_lost) begin
            n.arb_seen = 1'b1;
        end

        if (start_c) begin
            n.busy = 1'b1;
        end else if (stop_c) begin
            n.busy = 1'b0;
        end

        // ----------------------------------------
        // Transfer sequencing
        // ----------------------------------------
        if (n.stop_request) begin
            // Slave-side stop request only recovers the interface
            n.stop_request = 1'b0;
            n.state        = ST_IDLE;
            n.sda_oe       = 1'b0;
            n.scl_oe       = 1'b0;
        end else if ((start_c | stop_c) & addressed) begin
            n.irq_flag = 1'b1;
            n.status   = SC_STOP;
            n.sda_oe   = 1'b0;
            n.state    = ST_HOLD;
        end else if (start_c & (r.state != ST_HOLD)) begin
            n.state   = ST_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_oe  = 1'b0;
        end else if (stop_c & (r.state != ST_HOLD)) begin
            n.state  = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            case (r.state)
                ST_IDLE, ST_SKIP: begin
                    n.sda_oe = 1'b0;
                end

                ST_ADDR: begin
                    if (scl_rise) begin
                        n.shift   = {r.shift[6:0], r.sda_s};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == BITS_BYTE) begin
                        // Matching also runs asleep, from SCL edges alone
                        if (r.ack_enable & (own_hit | gc_match)) begin
                            n.sda_oe = 1'b1;
                            n.gc_hit = gc_match & ~own_hit;
                            n.state  = ST_AACK;
                        end else begin
                            n.state = ST_SKIP;
                        end
                    end
                end

                ST_AACK: begin
                    if (scl_fall) begin
                        n.sda_oe   = 1'b0;
                        n.irq_flag = 1'b1;
                        n.scl_oe   = 1'b1;
                        n.arb_seen = 1'b0;
                        n.state    = ST_HOLD;
                        if (r.gc_hit) begin
                            n.status = r.arb_seen ? SC_ARB_GC : SC_GC;
                        end else begin
                            n.status = r.arb_seen ? SC_ARB_OWN : SC_OWN_W;
                        end
                    end
                end

                ST_HOLD: begin
                    if (~r.irq_flag) begin
                        n.scl_oe = 1'b0;
                        if (r.status == SC_DAT_NAK || r.status == SC_GCD_NAK ||
                            r.status == SC_STOP) begin
                            n.state  = ST_IDLE;
                            n.status = SC_IDLE;
                        end else begin
                            n.state    = ST_DATA;
                            n.bit_cnt  = 4'h0;
                            n.ack_plan = r.ack_enable;
                        end
                    end else begin
                        n.scl_oe = (r.status != SC_STOP);
                    end
                end

                ST_DATA: begin
                    if (scl_rise) begin
                        n.shift   = {r.shift[6:0], r.sda_s};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == BITS_BYTE) begin
                        n.sda_oe = r.ack_plan;
                        if (~sleep_i) begin
                            n.data = r.shift;
                        end
                        n.state = ST_DACK;
                    end
                end

                ST_DACK: begin
                    if (scl_fall) begin
                        n.sda_oe   = 1'b0;
                        n.irq_flag = 1'b1;
                        n.scl_oe   = 1'b1;
                        n.state    = ST_HOLD;
                        if (r.gc_hit) begin
                            n.status = r.ack_plan ? SC_GCD_ACK : SC_GCD_NAK;
                        end else begin
                            n.status = r.ack_plan ? SC_DAT_ACK : SC_DAT_NAK;
                        end
                    end
                end

                default: begin
                    n.state = ST_IDLE;
                end
            endcase
        end

        if (~n.iface_enable) begin
            n.state  = ST_IDLE;
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
        end

        n.irq       = n.irq_flag & n.irq_enable;
        n.wake      = sleep_i & n.irq_flag & (n.state == ST_HOLD);
        n.start_out = n.start_request & n.iface_enable & ~n.busy;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r <= '{
                state:           ST_IDLE,
                scl_m:           1'b1,
                scl_s:           1'b1,
                scl_p:           1'b1,
                sda_m:           1'b1,
                sda_s:           1'b1,
                sda_p:           1'b1,
                busy:            1'b0,
                shift:           8'h00,
                bit_cnt:         4'h0,
                gc_hit:          1'b0,
                arb_seen:        1'b0,
                ack_plan:        1'b0,
                own_addr:        RST_OWN,
                irq_flag:        1'b0,
                ack_enable:      1'b0,
                start_request:   1'b0,
                stop_request:    1'b0,
                write_collision: 1'b0,
                iface_enable:    1'b0,
                irq_enable:      1'b0,
                presc:           2'h0,
                status:          SC_IDLE,
                data:            RST_DATA,
                sda_oe:          1'b0,
                scl_oe:          1'b0,
                irq:             1'b0,
                wake:            1'b0,
                start_out:       1'b0,
                pready:          1'b0,
                pslverr:         1'b0,
                prdata:          32'h0000_0000
            };
        end else begin
            r <= n;
        end
    end

endmodule // srx_slave_rx

`default_nettype wire

//--- srx_monitor.sv
// Port checker for the two-wire slave receiver.
// Assumes it is bound to srx_slave_rx and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module srx_monitor
    import srx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              core_clk, // System clock
    input wire logic              rst,      // Synchronous reset
    input wire logic              psel,     // APB select
    input wire logic              penable,  // APB access phase
    input wire logic              pwrite,   // APB direction
    input wire logic [ADDR_W-1:0] paddr,    // APB address
    input wire logic [31:0]       pwdata,   // APB write data
    input wire logic [31:0]       prdata,   // APB read data
    input wire logic              pready,   // APB ready
    input wire logic              pslverr,  // APB error
    input wire logic              scl_i,    // SCL wire level
    input wire logic              scl_o,    // SCL drive value
    input wire logic              scl_oe,   // SCL pull low
    input wire logic              sda_o,    // SDA drive value
    input wire logic              sda_oe,   // SDA pull low
    input wire logic              sleep_i,  // Deep sleep
    input wire logic              wake_o    // Wake request
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    logic clr_wr;
    assign clr_wr = psel && penable && pready && pwrite
                    && paddr == ADDR_W'(OFF_CTRL) && pwdata[7];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without ready or with data");
    a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin drive value not low");
    a_stretch_hold: assert property (scl_oe && !clr_wr && !$past(clr_wr) |=> scl_oe)
        else $error("SCL released before flag clear");
    a_stretch_release: assert property (scl_oe && clr_wr |-> ##[1:3] !scl_oe)
        else $error("SCL not released after flag clear");
    a_ack_low_scl: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
        else $error("wake without sleep");
endmodule // srx_monitor

`default_nettype wire

//--- srx_bus_master.sv
// Behavioural two-wire master transmitter with pull-up wire resolution.
// Assumes a 200 ns bus clock paced from the 25 ns system clock.
`timescale 1ns/1ps
`default_nettype none

module srx_bus_master (
    input  wire logic core_clk, // Pacing clock
    input  wire logic scl_oe,   // Device pulls SCL low
    input  wire logic sda_oe,   // Device pulls SDA low
    output logic      scl,      // Resolved SCL wire
    output logic      sda       // Resolved SDA wire
);
    // ----------------------------------------
    // Wires and frame tasks
    // ----------------------------------------
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    assign scl = m_scl & ~scl_oe;
    assign sda = m_sda & ~sda_oe;

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bit with SCL low on entry and on exit
    task automatic put_bit(input logic b, output logic r);
        tick(2);
        m_sda <= b;
        tick(2);
        m_scl <= 1'b1;
        for (int i = 0; i < 5000; i++) begin
            tick(1);
            if (scl === 1'b1) break;
        end
        tick(1);
        r = sda;
        tick(2);
        m_scl <= 1'b0;
    endtask

    task automatic frame_start();
        m_sda <= 1'b0;
        tick(4);
        m_scl <= 1'b0;
    endtask

    task automatic frame_stop();
        tick(2);
        m_sda <= 1'b0;
        tick(2);
        m_scl <= 1'b1;
        tick(4);
        m_sda <= 1'b1;
        tick(4);
    endtask

    // Most significant bit first, then released ack bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(b[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
endmodule // srx_bus_master

`default_nettype wire

//--- test_i2c_slave_receiver.sv
// Self-checking bench for the two-wire slave receiver.
// Assumes srx_bus_master as bus partner and APB software on core_clk.
`timescale 1ns/1ps
`default_nettype none

module test_i2c_slave_receiver;
    import srx_pkg::*;
    // ----------------------------------------
    // Signals, instances and tasks
    // ----------------------------------------
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        arb_lost = 0, sleep_i = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wake_o, start_o, irq_o;
    wire         scl, sda;
    int          error_cnt = 0, checks = 0;
    logic [7:0]  q[$];
    logic [7:0]  ra[4] = '{OFF_CTRL, OFF_STATUS, OFF_DATA, OFF_OWN};
    logic [7:0]  rv[4] = '{8'h00, SC_IDLE, RST_DATA, RST_OWN};
    logic [6:0]  sa;
    logic [7:0]  last_rx;

    srx_slave_rx uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_i(sleep_i),
        .wake_o(wake_o), .start_o(start_o), .irq_o(irq_o));
    srx_bus_master m (.core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl(scl), .sda(sda));

    initial forever #12.5 core_clk = ~core_clk;

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r & mask, exp);
    endtask

    task automatic wait_on(input int sel);
        for (int i = 0; i < 60 && (sel ? irq_o : scl_oe) !== 1'b1; i++) @(posedge core_clk);
    endtask

    function automatic logic [7:0] code_of(input int gc, input int arb, input int ph, input int ak);
        if (ph == 0) return gc ? (arb ? SC_ARB_GC : SC_GC) : (arb ? SC_ARB_OWN : SC_OWN_W);
        return gc ? (ak ? SC_GCD_ACK : SC_GCD_NAK) : (ak ? SC_DAT_ACK : SC_DAT_NAK);
    endfunction

    task automatic addr_hit(input logic [7:0] a, input int gc, input int arb);
        logic ak;
        if (arb) begin
            @(posedge core_clk);
            arb_lost <= 1;
            @(posedge core_clk);
            arb_lost <= 0;
        end
        m.frame_start();
        m.send_byte(a, ak);
        chk(ak, 1);
        wait_on(0);
        chk(scl_oe, 1);
        chk(irq_o, 1);
        rd(OFF_STATUS, 32'hF8, code_of(gc, arb, 0, 1));
    endtask

    task automatic data_byte(input int gc, input int ak_exp);
        logic [7:0] b;
        logic ak;
        b = 8'($urandom);
        q.push_back(b);
        last_rx = b;
        m.send_byte(b, ak);
        chk(ak, ak_exp);
        wait_on(0);
        chk(scl_oe, 1);
        rd(OFF_STATUS, 32'hF8, code_of(gc, 0, 1, ak_exp));
        rd(OFF_DATA, 32'hFF, q.pop_front());
    endtask

    task automatic stop_a0();
        m.frame_stop();
        wait_on(1);
        rd(OFF_STATUS, 32'hF8, SC_STOP);
        wr(OFF_CTRL, 8'hC5);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic e, ak;
        logic [7:0] miss[3];
        int s;
        s = $urandom(29);
        repeat (20) @(posedge core_clk);
        rst <= 0;
        for (int i = 0; i < 4; i++) rd(ra[i], 32'hFFFFFFFF, rv[i]);
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk(e, 1);
        chk(r, 0);
        sa = 7'h08 + 7'($urandom % 112);
        wr(OFF_OWN, {sa, 1'b1});
        wr(OFF_STATUS, 8'h03);
        wr(OFF_CTRL, 8'h45);
        for (int gc = 0; gc < 2; gc++)
            for (int arb = 0; arb < 2; arb++) begin
                addr_hit(gc ? GC_ADDR : {sa, 1'b0}, gc, arb);
                wr(OFF_CTRL, 8'hC5);
                data_byte(gc, 1);
                wr(OFF_CTRL, 8'h85);
                data_byte(gc, 0);
                wr(OFF_CTRL, 8'hC5);
                m.frame_stop();
            end
        addr_hit({sa, 1'b0}, 0, 0);
        wr(OFF_CTRL, 8'hC5);
        data_byte(0, 1);
        wr(OFF_CTRL, 8'hC5);
        stop_a0();
        addr_hit({sa, 1'b0}, 0, 0);
        wr(OFF_CTRL, 8'h85);
        data_byte(0, 0);
        wr(OFF_CTRL, 8'h85);
        m.frame_stop();
        m.frame_start();
        m.send_byte({sa, 1'b0}, ak);
        chk(ak, 0);
        m.frame_stop();
        wr(OFF_CTRL, 8'h45);
        addr_hit({sa, 1'b0}, 0, 0);
        wr(OFF_CTRL, 8'hC5);
        stop_a0();
        wr(OFF_OWN, {sa, 1'b0});
        miss = '{GC_ADDR, {sa, 1'b1}, {sa ^ 7'h01, 1'b0}};
        for (int i = 0; i < 3; i++) begin
            m.frame_start();
            m.send_byte(miss[i], ak);
            chk(ak, 0);
            m.frame_stop();
        end
        sleep_i <= 1;
        addr_hit({sa, 1'b0}, 0, 0);
        chk(wake_o, 1);
        wr(OFF_CTRL, 8'hC5);
        m.send_byte(8'($urandom), ak);
        chk(ak, 1);
        wait_on(0);
        rd(OFF_DATA, 32'hFF, last_rx);
        wr(OFF_CTRL, 8'hC5);
        sleep_i <= 0;
        stop_a0();
        wr(OFF_CTRL, 8'h65);
        repeat (3) @(posedge core_clk);
        chk(start_o, 1);
        wr(OFF_CTRL, 8'h45);
        wr(OFF_DATA, 8'h5A);
        rd(OFF_CTRL, 32'h08, 32'h08);
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end
endmodule // test_i2c_slave_receiver

bind srx_slave_rx srx_monitor #(.ADDR_W(ADDR_W)) u_mon (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .sleep_i(sleep_i), .wake_o(wake_o));

`default_nettype wire
